// ### design/ddd_pkg.sv
// Purpose: constants and types for the dial, tone detect and terminal ready bank
// Assumes: pclk at 20 MHz, registers on 32-bit APB words
// Notes: byte address of a documented register is four times its index
// Overview of operation
// - dual tone seen ignores timing criteria
// - tone word written when dual tone seen
// - tone detected flag needs all criteria
// - dial select one tones, zero pulses, default one
// - select change applies to the next digit
// - each transmit byte is one digit
// - pulse select picks off hook or relay_out_a relay
// - high speed handshake needs ready and data enable
// - high speed answer sends answer tone at once
// - low speed data state needs ready and enable
// - controlled carrier follows request to send in low speed only
// - clearing ready turns transmitter off in data
// - effective ready is bit or pin
// - data set ready follows circuit 107
package ddd_pkg;
	localparam int          ADDR_W           = 8;
	localparam int          TMR_W            = 24;
	localparam int          CLK_MHZ          = 20;
	localparam logic [7:0]  IDX_DIAL_TERM    = 8'h09;
	localparam logic [7:0]  IDX_LINE_STAT    = 8'h0f;
	localparam logic [7:0]  IDX_TONE_STAT    = 8'h1b;
	localparam logic [7:0]  ADR_DIAL_TERM    = 8'(IDX_DIAL_TERM * 4);
	localparam logic [7:0]  ADR_LINE_STAT    = 8'(IDX_LINE_STAT * 4);
	localparam logic [7:0]  ADR_TONE_STAT    = 8'(IDX_TONE_STAT * 4);
	localparam logic [7:0]  ADR_CONFIGURATION_CODE         = 8'h80;
	localparam logic [7:0]  ADR_MODE         = 8'h84;
	localparam logic [7:0]  ADR_TXDATA       = 8'h88;
	localparam logic [7:0]  ADR_IRQ_STAT     = 8'h8c;
	localparam logic [7:0]  ADR_IRQ_MASK     = 8'h90;
	localparam int          BIT_TERM_READY   = 0;
	localparam int          BIT_TONE_SEL     = 5;
	localparam int          BIT_DSR          = 4;
	localparam int          BIT_DUAL_SEEN    = 6;
	localparam int          BIT_TONE_DET     = 4;
	localparam int          BIT_DATA_EN      = 0;
	localparam int          BIT_ANSWER       = 1;
	localparam int          BIT_LOW_SPEED    = 2;
	localparam int          BIT_CTRL_CARRIER = 3;
	localparam int          BIT_RTS          = 4;
	localparam int          BIT_PULSE_SEL    = 5;
	localparam int          BIT_OFF_HOOK     = 6;
	localparam int          BIT_RELAY_OUT_A         = 7;
	localparam logic [7:0]  RST_DIAL_TERM    = 8'h20;
	localparam logic [7:0]  RST_CONFIGURATION_CODE         = 8'h00;
	localparam logic [7:0]  RST_MODE         = 8'h00;
	localparam logic [4:0]  RST_IRQ_MASK     = 5'h00;
	localparam logic [7:0]  CONFIGURATION_CODE_DIALING     = 8'h81;
	localparam logic [7:0]  MAX_PULSE_DIGIT  = 8'h09;
	localparam logic [7:0]  MAX_TONE_DIGIT   = 8'h0f;
	localparam logic [3:0]  ZERO_PULSES      = 4'ha;
	localparam int          BREAK_MS         = 60;
	localparam int          MAKE_MS          = 40;
	localparam int          TONE_MS          = 100;
	localparam int          GAP_MS           = 700;
	localparam int          BREAK_CYC        = BREAK_MS * CLK_MHZ * 1000;
	localparam int          MAKE_CYC         = MAKE_MS * CLK_MHZ * 1000;
	localparam int          TONE_CYC         = TONE_MS * CLK_MHZ * 1000;
	localparam int          GAP_CYC          = GAP_MS * CLK_MHZ * 1000;

	typedef struct packed {
		logic       dual;
		logic       full;
		logic [1:0] row;
		logic [1:0] col;
	} ddd_det_t;

	typedef struct packed {
		logic txbe;
		logic data_up;
		logic digit_done;
		logic tone_det;
		logic dual_seen;
	} ddd_irq_t;

	typedef enum logic [1:0] {LK_IDLE, LK_HANDSHAKE, LK_DATA} ddd_link_t;
	typedef enum logic [2:0] {DL_IDLE, DL_TONE, DL_BREAK, DL_MAKE, DL_GAP} ddd_dial_t;
endpackage

// ### design/ddd_bank.sv
// Purpose: host register bank for tone detect, digit dialing and terminal ready
// Assumes: detector and trainer logic on pclk; pins dtr and rts from outside
// Notes: one wait state on every apb access
`timescale 1ns/1ns
module ddd_bank #(
	parameter int unsigned BREAK_CYCLES = ddd_pkg::BREAK_CYC,
	parameter int unsigned MAKE_CYCLES  = ddd_pkg::MAKE_CYC,
	parameter int unsigned TONE_CYCLES  = ddd_pkg::TONE_CYC,
	parameter int unsigned GAP_CYCLES   = ddd_pkg::GAP_CYC
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ddd_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	output logic                           irq,
	input  wire ddd_pkg::ddd_det_t         det,
	input  wire logic                      train_done,
	input  wire logic                      dtr_pin_n,
	input  wire logic                      rts_pin_n,
	output logic                           handshake_start,
	output logic                           answer_tone,
	output logic                           data_state,
	output logic                           tx_on,
	output logic                           dsr_n,
	output logic                           off_hook_relay_out_n,
	output logic                           relay_out_a_n,
	output logic                           tone_dial_on,
	output logic      [3:0]                tone_dial_code
);
	// dtmf grid: rows 1 2 3 A / 4 5 6 B / 7 8 9 C / * 0 # D
	function automatic logic [3:0] encode_key(input logic [1:0] row, input logic [1:0] col);
		logic [3:0] code;
		code = 4'h0;
		if (col == 2'h3)
			code = 4'(4'hc + {2'h0, row});
		else if (row == 2'h3)
			code = (col == 2'h0) ? 4'ha : ((col == 2'h1) ? 4'h0 : 4'hb);
		else
			code = 4'(4'h1 + 4'({2'h0, row} * 4'h3) + {2'h0, col});
		return code;
	endfunction

	logic [7:0]         dial_term_ff;
	logic [7:0]         configuration_code_ff;
	logic [7:0]         mode_ff;
	logic [7:0]         txbuf_ff;
	logic               tx_empty_ff;
	ddd_pkg::ddd_irq_t  irq_stat_ff;
	ddd_pkg::ddd_irq_t  irq_mask_ff;
	ddd_pkg::ddd_irq_t  nxt_irq_stat;
	ddd_pkg::ddd_irq_t  events;
	logic [31:0]        rd_val;
	logic               rd_err;
	logic               acc;
	logic               wr;
	logic [2:0]         dtr_sync_ff;
	logic [2:0]         rts_sync_ff;
	logic               dtr_pin_ff;
	logic               rts_pin_ff;
	logic               dual_ff;
	logic               full_ff;
	logic [3:0]         tone_word_ff;
	ddd_pkg::ddd_link_t link_ff;
	ddd_pkg::ddd_dial_t dial_ff;
	logic [ddd_pkg::TMR_W-1:0] tmr_ff;
	logic [3:0]         pulses_ff;
	logic               brk_ff;
	logic               take;
	logic               digit_done;
	logic               dtr_eff;
	logic               dialing;
	logic               low_speed;
	logic               data_en;
	logic               answer;
	logic               rts_eff;

	assign acc       = psel && penable;
	assign wr        = acc && pready && pwrite && pstrb[0] && !rd_err;
	assign dialing   = (configuration_code_ff == ddd_pkg::CONFIGURATION_CODE_DIALING);
	assign low_speed = mode_ff[ddd_pkg::BIT_LOW_SPEED];
	assign data_en   = mode_ff[ddd_pkg::BIT_DATA_EN];
	assign answer    = mode_ff[ddd_pkg::BIT_ANSWER];
	assign dtr_eff   = dial_term_ff[ddd_pkg::BIT_TERM_READY] || dtr_pin_ff;
	assign rts_eff   = mode_ff[ddd_pkg::BIT_RTS] || rts_pin_ff;
	assign take      = (dial_ff == ddd_pkg::DL_IDLE) && dialing && !tx_empty_ff;

	// read mux and decode; unaligned or unmapped answers pslverr
	always_comb
	begin
		rd_val = 32'h0;
		rd_err = 1'b0;
		if (paddr[1:0] != 2'h0)
			rd_err = 1'b1;
		else
			unique case (paddr)
				ddd_pkg::ADR_DIAL_TERM: rd_val = {24'h0, dial_term_ff};
				ddd_pkg::ADR_LINE_STAT: rd_val = 32'(link_ff != ddd_pkg::LK_IDLE)
					<< ddd_pkg::BIT_DSR;
				ddd_pkg::ADR_TONE_STAT: rd_val = {24'h0, 1'b0, dual_ff, 1'b0, full_ff, tone_word_ff};
				ddd_pkg::ADR_CONFIGURATION_CODE:      rd_val = {24'h0, configuration_code_ff};
				ddd_pkg::ADR_MODE:      rd_val = {24'h0, mode_ff};
				ddd_pkg::ADR_TXDATA:    rd_val = {23'h0, tx_empty_ff, txbuf_ff};
				ddd_pkg::ADR_IRQ_STAT:  rd_val = {27'h0, irq_stat_ff};
				ddd_pkg::ADR_IRQ_MASK:  rd_val = {27'h0, irq_mask_ff};
				default:                rd_err = 1'b1;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else
		begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready && rd_err;
			prdata  <= (acc && !pready && !pwrite) ? rd_val : 32'h0;
		end
	end

	// control registers; tone select resets to one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dial_term_ff <= ddd_pkg::RST_DIAL_TERM;
			configuration_code_ff      <= ddd_pkg::RST_CONFIGURATION_CODE;
			mode_ff      <= ddd_pkg::RST_MODE;
			irq_mask_ff  <= ddd_pkg::RST_IRQ_MASK;
		end
		else if (wr)
		begin
			if (paddr == ddd_pkg::ADR_DIAL_TERM)
				dial_term_ff <= pwdata[7:0];
			if (paddr == ddd_pkg::ADR_CONFIGURATION_CODE)
				configuration_code_ff <= pwdata[7:0];
			if (paddr == ddd_pkg::ADR_MODE)
				mode_ff <= pwdata[7:0];
			if (paddr == ddd_pkg::ADR_IRQ_MASK)
				irq_mask_ff <= pwdata[4:0];
		end
	end

	// one digit holding byte; a write while full overwrites it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			txbuf_ff    <= 8'h00;
			tx_empty_ff <= 1'b1;
		end
		else if (wr && paddr == ddd_pkg::ADR_TXDATA)
		begin
			txbuf_ff    <= pwdata[7:0];
			tx_empty_ff <= 1'b0;
		end
		else if (take)
			tx_empty_ff <= 1'b1;
	end

	// pins: change counts once second and third stage agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dtr_sync_ff <= 3'h0;
			rts_sync_ff <= 3'h0;
			dtr_pin_ff  <= 1'b0;
			rts_pin_ff  <= 1'b0;
		end
		else
		begin
			dtr_sync_ff <= {dtr_sync_ff[1:0], !dtr_pin_n};
			rts_sync_ff <= {rts_sync_ff[1:0], !rts_pin_n};
			if (dtr_sync_ff[1] == dtr_sync_ff[2])
				dtr_pin_ff <= dtr_sync_ff[2];
			if (rts_sync_ff[1] == rts_sync_ff[2])
				rts_pin_ff <= rts_sync_ff[2];
		end
	end

	// tone detect status; word loads only on a new dual tone, else held
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dual_ff      <= 1'b0;
			full_ff      <= 1'b0;
			tone_word_ff <= 4'h0;
		end
		else
		begin
			dual_ff <= det.dual && dialing == 1'b0;
			full_ff <= det.full && det.dual && !dialing;
			if (det.dual && !dual_ff && !dialing)
				tone_word_ff <= encode_key(det.row, det.col);
		end
	end

	always_comb
	begin
		events            = '0;
		events.dual_seen  = det.dual && !dual_ff && !dialing;
		events.tone_det   = det.full && det.dual && !full_ff && !dialing;
		events.digit_done = digit_done;
		events.data_up    = (link_ff != ddd_pkg::LK_DATA) && (nxt_link_is_data());
		events.txbe       = take;
		// set wins over a clear in the same cycle
		nxt_irq_stat = irq_stat_ff;
		if (wr && paddr == ddd_pkg::ADR_IRQ_STAT)
			nxt_irq_stat = irq_stat_ff & ~ddd_pkg::ddd_irq_t'(pwdata[4:0]);
		nxt_irq_stat = nxt_irq_stat | events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat_ff <= '0;
			irq         <= 1'b0;
		end
		else
		begin
			irq_stat_ff <= nxt_irq_stat;
			irq         <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	function automatic logic nxt_link_is_data();
		logic d;
		d = 1'b0;
		if (link_ff == ddd_pkg::LK_IDLE)
			d = dtr_eff && data_en && !dialing && low_speed;
		else if (link_ff == ddd_pkg::LK_HANDSHAKE)
			d = dtr_eff && data_en && train_done;
		return d;
	endfunction

	// link sequencing: high speed trains first, low speed enters data at once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link_ff         <= ddd_pkg::LK_IDLE;
			handshake_start <= 1'b0;
		end
		else
		begin
			handshake_start <= 1'b0;
			unique case (link_ff)
				ddd_pkg::LK_IDLE:
					if (dtr_eff && data_en && !dialing)
					begin
						if (low_speed)
							link_ff <= ddd_pkg::LK_DATA;
						else
						begin
							link_ff         <= ddd_pkg::LK_HANDSHAKE;
							handshake_start <= 1'b1;
						end
					end
				ddd_pkg::LK_HANDSHAKE:
					if (!dtr_eff || !data_en)
						link_ff <= ddd_pkg::LK_IDLE;
					else if (train_done)
						link_ff <= ddd_pkg::LK_DATA;
				ddd_pkg::LK_DATA:
					if (!dtr_eff || !data_en)
						link_ff <= ddd_pkg::LK_IDLE;
			endcase
		end
	end

	// line side outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			answer_tone <= 1'b0;
			data_state  <= 1'b0;
			tx_on       <= 1'b0;
			dsr_n       <= 1'b1;
		end
		else
		begin
			// high speed sends answer tone from ready alone, until data state
			answer_tone <= answer && dtr_eff && !dialing &&
				(low_speed ? data_en : (link_ff != ddd_pkg::LK_DATA));
			data_state  <= (link_ff == ddd_pkg::LK_DATA);
			tx_on       <= (link_ff == ddd_pkg::LK_HANDSHAKE) ||
				((link_ff == ddd_pkg::LK_DATA) &&
				(!(low_speed && mode_ff[ddd_pkg::BIT_CTRL_CARRIER]) || rts_eff));
			dsr_n       <= !(link_ff != ddd_pkg::LK_IDLE);
		end
	end

	// dialer; method latched per digit so a select change hits the next one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dial_ff        <= ddd_pkg::DL_IDLE;
			tmr_ff         <= '0;
			pulses_ff      <= 4'h0;
			brk_ff         <= 1'b0;
			tone_dial_on   <= 1'b0;
			tone_dial_code <= 4'h0;
			digit_done     <= 1'b0;
		end
		else
		begin
			digit_done <= 1'b0;
			if (tmr_ff != '0)
				tmr_ff <= tmr_ff - 1'b1;
			if (!dialing && dial_ff != ddd_pkg::DL_IDLE)
			begin
				dial_ff      <= ddd_pkg::DL_IDLE;
				brk_ff       <= 1'b0;
				tone_dial_on <= 1'b0;
				tmr_ff       <= '0;
			end
			else
				unique case (dial_ff)
					ddd_pkg::DL_IDLE:
						if (take)
						begin
							if (dial_term_ff[ddd_pkg::BIT_TONE_SEL])
							begin
								if (txbuf_ff <= ddd_pkg::MAX_TONE_DIGIT)
								begin
									dial_ff        <= ddd_pkg::DL_TONE;
									tone_dial_on   <= 1'b1;
									tone_dial_code <= txbuf_ff[3:0];
									tmr_ff         <= ddd_pkg::TMR_W'(TONE_CYCLES - 1);
								end
							end
							else if (txbuf_ff <= ddd_pkg::MAX_PULSE_DIGIT)
							begin
								dial_ff   <= ddd_pkg::DL_BREAK;
								brk_ff    <= 1'b1;
								pulses_ff <= (txbuf_ff == 8'h00) ? ddd_pkg::ZERO_PULSES : txbuf_ff[3:0];
								tmr_ff    <= ddd_pkg::TMR_W'(BREAK_CYCLES - 1);
							end
						end
					ddd_pkg::DL_TONE:
						if (tmr_ff == '0)
						begin
							dial_ff      <= ddd_pkg::DL_GAP;
							tone_dial_on <= 1'b0;
							tmr_ff       <= ddd_pkg::TMR_W'(GAP_CYCLES - 1);
						end
					ddd_pkg::DL_BREAK:
						if (tmr_ff == '0)
						begin
							dial_ff <= ddd_pkg::DL_MAKE;
							brk_ff  <= 1'b0;
							tmr_ff  <= ddd_pkg::TMR_W'(MAKE_CYCLES - 1);
						end
					ddd_pkg::DL_MAKE:
						if (tmr_ff == '0)
						begin
							pulses_ff <= pulses_ff - 4'h1;
							if (pulses_ff == 4'h1)
							begin
								dial_ff <= ddd_pkg::DL_GAP;
								tmr_ff  <= ddd_pkg::TMR_W'(GAP_CYCLES - 1);
							end
							else
							begin
								dial_ff <= ddd_pkg::DL_BREAK;
								brk_ff  <= 1'b1;
								tmr_ff  <= ddd_pkg::TMR_W'(BREAK_CYCLES - 1);
							end
						end
					ddd_pkg::DL_GAP:
						if (tmr_ff == '0)
						begin
							dial_ff    <= ddd_pkg::DL_IDLE;
							digit_done <= 1'b1;
						end
				endcase
		end
	end

	// relays active low; a break opens the selected relay only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			off_hook_relay_out_n <= 1'b1;
			relay_out_a_n        <= 1'b1;
		end
		else
		begin
			off_hook_relay_out_n <= !(mode_ff[ddd_pkg::BIT_OFF_HOOK] &&
				!(brk_ff && !mode_ff[ddd_pkg::BIT_PULSE_SEL]));
			relay_out_a_n        <= !(mode_ff[ddd_pkg::BIT_RELAY_OUT_A] &&
				!(brk_ff && mode_ff[ddd_pkg::BIT_PULSE_SEL]));
		end
	end
endmodule

// ### bench/ddd_bank_assertions.sv
// Purpose: port checker for the dial, tone detect and terminal ready bank
// Assumes: one clock, asynchronous active low reset
// Notes: bound to the design from the testbench top file
`timescale 1ns/1ns
module ddd_bank_chk #(
	parameter int unsigned TONE_CYCLES = 10
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        handshake_start,
	input wire logic        data_state,
	input wire logic        dsr_n,
	input wire logic        tone_dial_on,
	input wire logic [3:0]  tone_dial_code
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	int unsigned tone_cnt_ff;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			tone_cnt_ff <= 0;
		else
			tone_cnt_ff <= tone_dial_on ? tone_cnt_ff + 1 : 0;
	ready_wait_a:
		assert property (psel && $rose(penable) |=> pready)
		else $error("pready not one cycle after access");
	ready_pulse_a:
		assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	slverr_ready_a:
		assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a:
		assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	tone_len_a:
		assert property ($fell(tone_dial_on) |-> tone_cnt_ff == TONE_CYCLES)
		else $error("tone burst length wrong");
	tone_code_a:
		assert property (tone_dial_on && $past(tone_dial_on) |-> $stable(tone_dial_code))
		else $error("tone code moved in burst");
	hs_pulse_a:
		assert property (handshake_start |=> !handshake_start ##1 !handshake_start)
		else $error("handshake start not a pulse");
	hs_from_idle_a:
		assert property (handshake_start |-> !data_state)
		else $error("handshake start while in data");
	hs_dsr_a:
		assert property (handshake_start |-> ##[0:2] !dsr_n)
		else $error("dsr not active in handshake");
	data_dsr_a:
		assert property (data_state && $past(data_state) |-> !dsr_n)
		else $error("dsr not active in data");
endmodule

// ### bench/ddd_line_model.sv
// Purpose: line side model: tone detector, trainer and terminal pins
// Assumes: driven from the testbench through its tasks
// Notes: all changes land by non-blocking assignment after a rising edge
`timescale 1ns/1ns
module ddd_line_model (
	input  wire logic         pclk,
	output ddd_pkg::ddd_det_t det,
	output logic              train_done,
	output logic              dtr_pin_n,
	output logic              rts_pin_n
);
	initial
	begin
		det = 6'h0f;
		train_done = 1'b0;
		dtr_pin_n = 1'b1;
		rts_pin_n = 1'b1;
	end
	// full never without dual: timing is judged only on a tone already seen
	task automatic set_det(input logic dl, input logic fl, input logic [3:0] key);
		@(posedge pclk);
		det <= '{dual: dl, full: fl & dl, row: key[3:2], col: key[1:0]};
	endtask
	task automatic set_train(input logic v);
		@(posedge pclk);
		train_done <= v;
	endtask
	task automatic set_pins(input logic dtr_n, input logic rts_n);
		@(posedge pclk);
		dtr_pin_n <= dtr_n;
		rts_pin_n <= rts_n;
	endtask
endmodule

// ### bench/ddd_bank_tb.sv
// Purpose: self-checking bench for the dial, tone detect and ready bank
// Assumes: apb master tasks, line model for detector and pins
// Notes: dial times shortened through the bank parameters
`timescale 1ns/1ns
module ddd_bank_tb;
	localparam logic [3:0] ENC [16] = '{4'h1, 4'h2, 4'h3, 4'hc, 4'h4, 4'h5, 4'h6, 4'hd,
		4'h7, 4'h8, 4'h9, 4'he, 4'ha, 4'h0, 4'hb, 4'hf};
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, irq, train_done, dtr_pin_n;
	logic rts_pin_n, handshake_start, answer_tone, data_state, tx_on, dsr_n;
	logic off_hook_relay_out_n, relay_out_a_n, tone_dial_on, oh_q, ra_q;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, tone_dial_code;
	ddd_pkg::ddd_det_t det;
	int unsigned err_total = 0, checked = 0, tog_oh = 0, tog_ra = 0, tone_cyc = 0, hs_cnt = 0;
	always #25 pclk = ~pclk;
	ddd_bank #(.BREAK_CYCLES(8), .MAKE_CYCLES(6), .TONE_CYCLES(10), .GAP_CYCLES(12)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .irq, .det, .train_done, .dtr_pin_n, .rts_pin_n,
		.handshake_start, .answer_tone, .data_state, .tx_on, .dsr_n,
		.off_hook_relay_out_n, .relay_out_a_n, .tone_dial_on, .tone_dial_code);
	ddd_line_model line (.pclk, .det, .train_done, .dtr_pin_n, .rts_pin_n);
	always @(posedge pclk)
	begin
		oh_q <= off_hook_relay_out_n;
		ra_q <= relay_out_a_n;
		if (presetn && oh_q !== off_hook_relay_out_n)
			tog_oh++;
		if (presetn && ra_q !== relay_out_a_n)
			tog_ra++;
		if (tone_dial_on === 1'b1)
			tone_cyc++;
		if (handshake_start === 1'b1)
			hs_cnt++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			err_total++;
		end
	endtask
	task automatic summarize();
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		if (n == 20)
			err_total++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so a next call never re-raises psel in this step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		logic e;
		apb(1'b1, a, wd, d, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 32'h0, d, e);
		check(d, exp);
	endtask
	task automatic t_regs();
		logic [31:0] d;
		logic e;
		rd_chk(ddd_pkg::ADR_DIAL_TERM, 32'h20);
		rd_chk(ddd_pkg::ADR_LINE_STAT, 32'h0);
		// strobe low: the write must be dropped
		pstrb <= 4'h0;
		wr(ddd_pkg::ADR_DIAL_TERM, 32'h01);
		pstrb <= 4'hf;
		rd_chk(ddd_pkg::ADR_DIAL_TERM, 32'h20);
		wr(ddd_pkg::ADR_TONE_STAT, 32'hff);
		apb(1'b0, ddd_pkg::ADR_TONE_STAT, 32'h0, d, e);
		check(d & 32'h50, 32'h0);
		apb(1'b0, 8'h04, 32'h0, d, e);
		check({31'h0, e}, 32'h1);
	endtask
	task automatic t_detect();
		wr(ddd_pkg::ADR_IRQ_MASK, 32'h03);
		for (int k = 0; k < 16; k++)
		begin
			line.set_det(1'b1, 1'b0, 4'(k));
			rd_chk(ddd_pkg::ADR_TONE_STAT, {24'h0, 4'h4, ENC[k]});
			line.set_det(1'b1, 1'b1, 4'(k));
			rd_chk(ddd_pkg::ADR_TONE_STAT, {24'h0, 4'h5, ENC[k]});
			line.set_det(1'b0, 1'b0, ~4'(k));
			rd_chk(ddd_pkg::ADR_TONE_STAT, {24'h0, 4'h0, ENC[k]});
		end
		check({31'h0, irq}, 32'h1);
		wr(ddd_pkg::ADR_IRQ_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		rd_chk(ddd_pkg::ADR_IRQ_STAT, 32'h03);
		wr(ddd_pkg::ADR_IRQ_STAT, 32'h1f);
		rd_chk(ddd_pkg::ADR_IRQ_STAT, 32'h0);
	endtask
	// waits on digit done; counters are diffed so the sampler never races the bench
	task automatic dial(input logic [7:0] dg, input int oh, input int ra, input int tn);
		int unsigned b0, b1, b2;
		logic [31:0] d;
		logic e;
		b0 = tog_oh;
		b1 = tog_ra;
		b2 = tone_cyc;
		d = 32'h0;
		wr(ddd_pkg::ADR_TXDATA, {24'h0, dg});
		for (int n = 0; n < 100 && d[2] !== 1'b1; n++)
			apb(1'b0, ddd_pkg::ADR_IRQ_STAT, 32'h0, d, e);
		check({31'h0, d[2]}, 32'h1);
		wr(ddd_pkg::ADR_IRQ_STAT, 32'h1f);
		check(32'(tog_oh - b0), 32'(oh));
		check(32'(tog_ra - b1), 32'(ra));
		check(32'(tone_cyc - b2), 32'(tn));
		if (tn > 0)
			check({28'h0, tone_dial_code}, {24'h0, dg});
	endtask
	// both relays closed first, so only dial breaks move them inside a digit
	task automatic t_dial();
		wr(ddd_pkg::ADR_MODE, 32'hc0);
		wr(ddd_pkg::ADR_CONFIGURATION_CODE, 32'h81);
		dial(8'h05, 0, 0, 10);
		wr(ddd_pkg::ADR_DIAL_TERM, 32'h00);
		dial(8'h02, 4, 0, 0);
		wr(ddd_pkg::ADR_MODE, 32'he0);
		dial(8'h00, 0, 20, 0);
		wr(ddd_pkg::ADR_DIAL_TERM, 32'h20);
		dial(8'h0b, 0, 0, 10);
		wr(ddd_pkg::ADR_CONFIGURATION_CODE, 32'h00);
	endtask
	task automatic t_link();
		int unsigned b;
		b = hs_cnt;
		wr(ddd_pkg::ADR_MODE, 32'h02);
		wr(ddd_pkg::ADR_DIAL_TERM, 32'h21);
		repeat (4) @(posedge pclk);
		check(32'(hs_cnt - b), 32'h0);
		wr(ddd_pkg::ADR_MODE, 32'h03);
		repeat (4) @(posedge pclk);
		check(32'(hs_cnt - b), 32'h1);
		check({answer_tone, data_state}, 32'h2);
		rd_chk(ddd_pkg::ADR_LINE_STAT, 32'h10);
		line.set_train(1'b1);
		repeat (4) @(posedge pclk);
		check({data_state, tx_on}, 32'h3);
		wr(ddd_pkg::ADR_DIAL_TERM, 32'h20);
		repeat (4) @(posedge pclk);
		check({data_state, tx_on, dsr_n}, 32'h1);
		line.set_train(1'b0);
		wr(ddd_pkg::ADR_MODE, 32'h0f);
		line.set_pins(1'b0, 1'b1);
		repeat (8) @(posedge pclk);
		check({answer_tone, data_state, tx_on}, 32'h6);
		line.set_pins(1'b0, 1'b0);
		repeat (8) @(posedge pclk);
		check({31'h0, tx_on}, 32'h1);
		line.set_pins(1'b1, 1'b1);
		wr(ddd_pkg::ADR_MODE, 32'h1d);
		repeat (8) @(posedge pclk);
		check({data_state, tx_on}, 32'h0);
	endtask
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_detect();
		t_dial();
		t_link();
		summarize();
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		summarize();
	end
endmodule
bind ddd_bank ddd_bank_chk #(.TONE_CYCLES(TONE_CYCLES)) chk (.pclk, .presetn, .psel,
	.penable, .prdata, .pready, .pslverr, .handshake_start, .data_state, .dsr_n,
	.tone_dial_on, .tone_dial_code);
